//--- core/prr_pkg.sv
/*
 * Shared constants for the processor restart and request-phase ends.
 * Assumes one bus clock of 125 MHz shared by both ends.
 */
package prr_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS     = 8;
  localparam int RESTART_PULSE_MS  = 1;
  localparam int RESTART_CYCLES    =
    (RESTART_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CLOCKS    = 2;
  localparam int SELFTEST_CYCLES   = 64;

  // ----------------------------------------
  // Request phase
  // ----------------------------------------
  localparam int REQ_W             = 5;
  localparam int CODE_W            = 2 * REQ_W;
  localparam int ADDR_W            = 36;
  localparam logic [ADDR_W-1:0] RESET_VECTOR = 36'h0_ffff_fff0;

  // ----------------------------------------
  // Power-on configuration, sampled from the request lines
  // ----------------------------------------
  localparam int CFG_W             = REQ_W;
  localparam int CFG_FLOAT_BIT     = 0;
  localparam logic [CFG_W-1:0] CFG_NONE = 5'h00;

  typedef enum logic [2:0] {
    PRR_HOLD,
    PRR_SELFTEST,
    PRR_FETCH,
    PRR_RUN,
    PRR_FLOAT
  } prr_cpu_state_t;

  typedef enum logic [1:0] {
    PRR_SYS_OFF,
    PRR_SYS_RESTART,
    PRR_SYS_ON
  } prr_sys_state_t;

  // Parity high when an even number of the active-low lines are low
  function automatic logic prr_cmd_parity(input logic ads_n,
                                          input logic [REQ_W-1:0] req_n);
    prr_cmd_parity = ~(^(~{ads_n, req_n}));
  endfunction

endpackage

//--- core/prr_bus_if.sv
/*
 * Pins between the processor end and the system core logic end.
 * Assumes both ends share the bus clock; lines idle high when undriven.
 */
`timescale 1ns/10ps
interface prr_bus_if;
  import prr_pkg::*;

  // ----------------------------------------
  // System to processor
  // ----------------------------------------
  logic             supply_ok;
  logic             restart_n;
  logic             warm_init_n;
  logic             legacy_second_restart_n;

  // ----------------------------------------
  // Shared request-phase lines, per-driver parts
  // ----------------------------------------
  logic             cpu_ads_o;
  logic             cpu_ads_oe;
  logic [REQ_W-1:0] cpu_req_o;
  logic             cpu_req_oe;
  logic             cpu_par_o;
  logic             cpu_par_oe;
  logic [REQ_W-1:0] sys_req_o;
  logic             sys_req_oe;

  // ----------------------------------------
  // Resolved wire levels
  // ----------------------------------------
  logic             address_strobe_n;
  logic [REQ_W-1:0] req_n;
  logic             command_parity_n;

  assign address_strobe_n = cpu_ads_oe ? cpu_ads_o : 1'b1;
  assign req_n            = cpu_req_oe ? cpu_req_o :
                            sys_req_oe ? sys_req_o : {REQ_W{1'b1}};
  assign command_parity_n = cpu_par_oe ? cpu_par_o : 1'b1;

  modport cpu (
    input  supply_ok, restart_n, warm_init_n, legacy_second_restart_n,
    input  address_strobe_n, req_n, command_parity_n,
    output cpu_ads_o, cpu_ads_oe, cpu_req_o, cpu_req_oe,
    output cpu_par_o, cpu_par_oe
  );

  modport sys (
    output supply_ok, restart_n, warm_init_n, legacy_second_restart_n,
    output sys_req_o, sys_req_oe,
    input  address_strobe_n, req_n, command_parity_n
  );
endinterface

//--- core/prr_cpu_end.sv
/*
 * Processor end: restart handling, power-on configuration capture,
 * optional self-test, reset vector fetch and request-phase driving.
 * Assumes the system end keeps the supply and restart sequencing.
 */
`timescale 1ns/10ps

// Contract
// - System holds supply_ok low, then rises cleanly
// - supply_ok may drop; restabilise before rising
// - 1 ms restart pulse follows supply_ok
// - supply_ok stays high during boundary scan
// - Restart gives known state, caches dropped
// - Power-on restart held at least 1 ms
// - Bus outputs released within two clocks; released here on the third edge after restart falls
// - Configuration captured at restart release
// - Float configuration keeps all outputs off
// - Warm-init at release runs self-test
// - Fetch starts at restart vector
// - Second-restart pin ignored
// - Owner drives type code over two clocks
// - Initiator drives parity over strobe, code
// - Parity high for even count of lows
module prr_cpu_end #(
  parameter int SELFTEST_CYCLES = prr_pkg::SELFTEST_CYCLES
) (
  // Clock and reset
  input  wire logic                         CORE_CLK_IN,
  input  wire logic                         RESET_IN,
  // Pins
  prr_bus_if.cpu                            BUS,
  // Request side
  input  wire logic                         REQ_VALID_IN,
  input  wire logic [prr_pkg::CODE_W-1:0]   REQ_CODE_IN,
  output logic                              REQ_READY_OUT,
  // Status side
  output logic                              CACHE_INVALIDATE_OUT,
  output logic                              SELFTEST_BUSY_OUT,
  output logic                              FETCH_START_OUT,
  output logic [prr_pkg::ADDR_W-1:0]        FETCH_ADDR_OUT,
  output logic                              OUTPUTS_FLOATED_OUT,
  output logic [prr_pkg::CFG_W-1:0]         CONFIG_OUT
);
  import prr_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0]       supply_sync_reg;
  logic [1:0]       restart_sync_reg;
  logic [1:0]       init_sync_reg;
  logic [REQ_W-1:0] strap_meta_reg;
  logic [REQ_W-1:0] strap_sync_reg;
  logic             in_restart;
  logic             restart_prev_reg;
  logic             release_edge;

  // Straps pass the same two stages so they line up with the restart copy
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      supply_sync_reg  <= 2'h0;
      restart_sync_reg <= 2'h0;
      init_sync_reg    <= 2'h3;
      strap_meta_reg   <= {REQ_W{1'b1}};
      strap_sync_reg   <= {REQ_W{1'b1}};
    end else begin
      supply_sync_reg  <= {supply_sync_reg[0], BUS.supply_ok};
      restart_sync_reg <= {restart_sync_reg[0], BUS.restart_n};
      init_sync_reg    <= {init_sync_reg[0], BUS.warm_init_n};
      strap_meta_reg   <= BUS.req_n;
      strap_sync_reg   <= strap_meta_reg;
    end
  end

  // Low supply is treated like restart, protecting internal state
  assign in_restart = ~restart_sync_reg[1] | ~supply_sync_reg[1];

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      restart_prev_reg <= 1'b1;
    end else begin
      restart_prev_reg <= in_restart;
    end
  end

  assign release_edge = restart_prev_reg & ~in_restart;

  // The second-restart pin is left unread on purpose

  // ----------------------------------------
  // Sequencing state machine
  // ----------------------------------------
  prr_cpu_state_t   state_reg;
  prr_cpu_state_t   state_next;
  logic [31:0]      selftest_cnt_reg;
  logic [CFG_W-1:0] cfg_reg;
  logic             init_at_release;
  logic             req_phase_reg;

  assign init_at_release = ~init_sync_reg[1];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PRR_HOLD: begin
        if (release_edge) begin
          if (strap_sync_reg[CFG_FLOAT_BIT] == 1'b0) begin
            state_next = PRR_FLOAT;
          end else if (init_at_release) begin
            state_next = PRR_SELFTEST;
          end else begin
            state_next = PRR_FETCH;
          end
        end
      end
      PRR_SELFTEST: begin
        if (selftest_cnt_reg == 32'(SELFTEST_CYCLES - 1)) begin
          state_next = PRR_FETCH;
        end
      end
      PRR_FETCH: begin
        state_next = PRR_RUN;
      end
      PRR_RUN: begin
        state_next = PRR_RUN;
      end
      PRR_FLOAT: begin
        state_next = PRR_FLOAT;
      end
    endcase
    if (in_restart) begin
      state_next = PRR_HOLD;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      state_reg <= PRR_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      selftest_cnt_reg <= 32'h0;
    end else if (state_reg == PRR_SELFTEST) begin
      selftest_cnt_reg <= selftest_cnt_reg + 32'h1;
    end else begin
      selftest_cnt_reg <= 32'h0;
    end
  end

  // Active-high copy of the straps at the release edge
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      cfg_reg <= CFG_NONE;
    end else if (!in_restart && release_edge) begin
      cfg_reg <= ~strap_sync_reg;
    end
  end

  // ----------------------------------------
  // Request phase driver
  // ----------------------------------------
  logic             ads_o_reg;
  logic             req_oe_reg;
  logic [REQ_W-1:0] req_o_reg;
  logic             par_o_reg;
  logic [REQ_W-1:0] second_half_reg;
  logic             accept;

  // Back-to-back requests are not possible; the next accept comes after two idle cycles
  assign accept = REQ_VALID_IN & REQ_READY_OUT;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN || in_restart) begin
      // Drops one edge after the synchronised restart is seen
      ads_o_reg       <= 1'b1;
      req_oe_reg      <= 1'b0;
      req_o_reg       <= {REQ_W{1'b1}};
      par_o_reg       <= 1'b1;
      req_phase_reg   <= 1'b0;
      second_half_reg <= {REQ_W{1'b1}};
    end else if (accept) begin
      // Code is active high at the port, driven inverted on the pins
      ads_o_reg       <= 1'b0;
      req_oe_reg      <= 1'b1;
      req_o_reg       <= ~REQ_CODE_IN[REQ_W-1:0];
      second_half_reg <= ~REQ_CODE_IN[CODE_W-1:REQ_W];
      par_o_reg       <= prr_cmd_parity(1'b0,
                                        ~REQ_CODE_IN[REQ_W-1:0]);
      req_phase_reg   <= 1'b1;
    end else if (req_phase_reg) begin
      ads_o_reg       <= 1'b1;
      req_o_reg       <= second_half_reg;
      par_o_reg       <= prr_cmd_parity(1'b1, second_half_reg);
      req_phase_reg   <= 1'b0;
    end else begin
      ads_o_reg       <= 1'b1;
      req_oe_reg      <= 1'b0;
      req_o_reg       <= {REQ_W{1'b1}};
      par_o_reg       <= 1'b1;
    end
  end

  assign BUS.cpu_ads_o  = ads_o_reg;
  assign BUS.cpu_ads_oe = req_oe_reg;
  assign BUS.cpu_req_o  = req_o_reg;
  assign BUS.cpu_req_oe = req_oe_reg;
  assign BUS.cpu_par_o  = par_o_reg;
  assign BUS.cpu_par_oe = req_oe_reg;

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      REQ_READY_OUT        <= 1'b0;
      CACHE_INVALIDATE_OUT <= 1'b1;
      SELFTEST_BUSY_OUT    <= 1'b0;
      FETCH_START_OUT      <= 1'b0;
      FETCH_ADDR_OUT       <= RESET_VECTOR;
      OUTPUTS_FLOATED_OUT  <= 1'b0;
      CONFIG_OUT           <= CFG_NONE;
    end else begin
      // Ready only in run with no phase pending or starting
      REQ_READY_OUT        <= (state_next == PRR_RUN) && !in_restart &&
                              !accept && !req_phase_reg;
      CACHE_INVALIDATE_OUT <= in_restart;
      SELFTEST_BUSY_OUT    <= (state_next == PRR_SELFTEST);
      FETCH_START_OUT      <= (state_next == PRR_FETCH);
      FETCH_ADDR_OUT       <= RESET_VECTOR;
      OUTPUTS_FLOATED_OUT  <= (state_next == PRR_FLOAT);
      CONFIG_OUT           <= cfg_reg;
    end
  end

endmodule

//--- core/prr_sys_end.sv
/*
 * System core logic end: power-good and restart sequencing, strap
 * driving during restart, and request-phase decode with parity check.
 * Assumes SUPPLY_STABLE_IN comes from logic on the same clock.
 */
`timescale 1ns/10ps
module prr_sys_end #(
  parameter int RESTART_CYCLES = prr_pkg::RESTART_CYCLES
) (
  // Clock and reset
  input  wire logic                         CORE_CLK_IN,
  input  wire logic                         RESET_IN,
  // Pins
  prr_bus_if.sys                            BUS,
  // Sequencing side
  input  wire logic                         SUPPLY_STABLE_IN,
  input  wire logic [prr_pkg::CFG_W-1:0]    STRAP_CFG_IN,
  input  wire logic                         SELFTEST_ASK_IN,
  output logic                              RESTART_ACTIVE_OUT,
  // Request decode side
  output logic                              TXN_VALID_OUT,
  output logic [prr_pkg::CODE_W-1:0]        TXN_CODE_OUT,
  output logic                              PARITY_ERR_OUT
);
  import prr_pkg::*;

  // ----------------------------------------
  // Supply and restart sequencing
  // ----------------------------------------
  prr_sys_state_t state_reg;
  logic [31:0]    count_reg;
  logic           supply_ok_reg;
  logic           restart_n_reg;

  // A dropped supply restarts the whole sequence from power-off
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      state_reg     <= PRR_SYS_OFF;
      count_reg     <= 32'h0;
      supply_ok_reg <= 1'b0;
      restart_n_reg <= 1'b0;
    end else if (!SUPPLY_STABLE_IN) begin
      state_reg     <= PRR_SYS_OFF;
      count_reg     <= 32'h0;
      supply_ok_reg <= 1'b0;
      restart_n_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        PRR_SYS_OFF: begin
          state_reg     <= PRR_SYS_RESTART;
          supply_ok_reg <= 1'b1;
        end
        PRR_SYS_RESTART: begin
          count_reg <= count_reg + 32'h1;
          if (count_reg == 32'(RESTART_CYCLES - 1)) begin
            state_reg     <= PRR_SYS_ON;
            restart_n_reg <= 1'b1;
          end
        end
        PRR_SYS_ON: begin
          supply_ok_reg <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Straps, held through release, then let go
  // ----------------------------------------
  logic             strap_oe_reg;
  logic [REQ_W-1:0] strap_o_reg;
  logic             init_n_reg;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      strap_oe_reg <= 1'b0;
      strap_o_reg  <= {REQ_W{1'b1}};
      init_n_reg   <= 1'b1;
    end else begin
      // Kept one clock past release so the processor sees them settled
      strap_oe_reg <= ~restart_n_reg;
      strap_o_reg  <= ~STRAP_CFG_IN;
      init_n_reg   <= ~(SELFTEST_ASK_IN & ~restart_n_reg);
    end
  end

  assign BUS.supply_ok               = supply_ok_reg;
  assign BUS.restart_n               = restart_n_reg;
  assign BUS.warm_init_n             = init_n_reg;
  assign BUS.legacy_second_restart_n = 1'b1;
  assign BUS.sys_req_o               = strap_o_reg;
  assign BUS.sys_req_oe              = strap_oe_reg;

  // ----------------------------------------
  // Request phase decode
  // ----------------------------------------
  logic             second_reg;
  logic [REQ_W-1:0] first_half_reg;
  logic             first_bad_reg;
  logic             par_bad;

  assign par_bad = BUS.command_parity_n !=
                   prr_cmd_parity(BUS.address_strobe_n, BUS.req_n);

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN || !restart_n_reg) begin
      second_reg     <= 1'b0;
      first_half_reg <= {REQ_W{1'b0}};
      first_bad_reg  <= 1'b0;
      TXN_VALID_OUT  <= 1'b0;
      TXN_CODE_OUT   <= {CODE_W{1'b0}};
      PARITY_ERR_OUT <= 1'b0;
    end else begin
      TXN_VALID_OUT  <= 1'b0;
      PARITY_ERR_OUT <= 1'b0;
      if (second_reg) begin
        second_reg     <= 1'b0;
        TXN_VALID_OUT  <= 1'b1;
        TXN_CODE_OUT   <= {~BUS.req_n, first_half_reg};
        PARITY_ERR_OUT <= first_bad_reg | par_bad;
      end else if (!BUS.address_strobe_n) begin
        second_reg     <= 1'b1;
        first_half_reg <= ~BUS.req_n;
        first_bad_reg  <= par_bad;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      RESTART_ACTIVE_OUT <= 1'b1;
    end else begin
      RESTART_ACTIVE_OUT <= ~restart_n_reg;
    end
  end

endmodule

//--- tb/prr_chk_sva.sv
/*
 * Checker on the pins between the processor and system ends.
 * Assumes one bus clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module prr_chk
  import prr_pkg::*;
#(
  parameter int RESTART_CYCLES = prr_pkg::RESTART_CYCLES
) (
  input logic             CORE_CLK_IN,
  input logic             RESET_IN,
  input logic             supply_ok,
  input logic             restart_n,
  input logic             legacy_second_restart_n,
  input logic             cpu_ads_oe,
  input logic             cpu_req_oe,
  input logic             cpu_par_oe,
  input logic             sys_req_oe,
  input logic             address_strobe_n,
  input logic [REQ_W-1:0] req_n,
  input logic             command_parity_n
);
  // ----------
  // Restart length
  // ----------
  int held_reg;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN || !supply_ok || restart_n) begin
      held_reg <= 0;
    end else if (held_reg < RESTART_CYCLES) begin
      held_reg <= held_reg + 1;
    end
  end

  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  // ----------
  // Properties
  // ----------
  chk_release_outputs: assert property ((!restart_n) [*4] |->
    !(cpu_ads_oe || cpu_req_oe || cpu_par_oe))
    else $error("bus outputs still driven in restart");
  chk_no_contention: assert property (!(cpu_req_oe && sys_req_oe))
    else $error("both ends drive the request lines");
  // Six lines: odd count of lows means odd count of highs
  chk_parity_even: assert property (cpu_par_oe |->
    command_parity_n == ~^{address_strobe_n, req_n})
    else $error("command parity wrong");
  chk_code_two_clk: assert property ($fell(address_strobe_n) |->
    cpu_req_oe ##1 (address_strobe_n && cpu_req_oe) ##1 !cpu_req_oe)
    else $error("type code not two clocks");
  chk_strobe_single: assert property (!address_strobe_n |=>
    address_strobe_n)
    else $error("strobe longer than one clock");
  chk_restart_held: assert property ($rose(restart_n) |->
    held_reg >= RESTART_CYCLES - 1)
    else $error("restart pulse too short");
  chk_supply_first: assert property (restart_n |-> supply_ok)
    else $error("restart released without supply");
  chk_legacy_idle: assert property (legacy_second_restart_n)
    else $error("second restart pin not idle");
  chk_strap_release: assert property ($rose(restart_n) |->
    sys_req_oe ##1 !sys_req_oe)
    else $error("straps not held over release");

  cover property ($fell(address_strobe_n));
  cover property ($rose(restart_n));
  cover property ($fell(supply_ok));
endmodule

//--- tb/test_processor_reset_and_request_phase.sv
/*
 * Self-checking bench: both ends joined by the pin interface.
 * Assumes the package constants and the checker module.
 */
`timescale 1ns/10ps
module test_processor_reset_and_request_phase;
  import prr_pkg::*;

  // ----------
  // Stimulus, observation, ends
  // ----------
  localparam int RC = 20;
  localparam int ST = 4;
  localparam logic [CODE_W-1:0] CODES [4] =
    '{10'h000, 10'h3ff, 10'h2a5, 10'h15a};
  logic              core_clk      = 1'b0;
  logic              reset         = 1'b1;
  logic              req_valid     = 1'b0;
  logic [CODE_W-1:0] req_code      = 10'h000;
  logic              supply_stable = 1'b0;
  logic [CFG_W-1:0]  strap_cfg     = 5'h00;
  logic              selftest_ask  = 1'b0;
  logic              ready, cache_inv, st_busy, fetch_start, floated;
  logic [ADDR_W-1:0] fetch_addr;
  logic [CFG_W-1:0]  config_seen;
  logic              restart_active, txn_valid, parity_err;
  logic [CODE_W-1:0] txn_code;
  int                errors = 0;
  int                compares = 0;

  always #4 core_clk = ~core_clk;

  prr_bus_if pins ();
  prr_cpu_end #(.SELFTEST_CYCLES(ST)) prr_cpu_end_i (
    .CORE_CLK_IN(core_clk), .RESET_IN(reset), .BUS(pins),
    .REQ_VALID_IN(req_valid), .REQ_CODE_IN(req_code),
    .REQ_READY_OUT(ready), .CACHE_INVALIDATE_OUT(cache_inv),
    .SELFTEST_BUSY_OUT(st_busy), .FETCH_START_OUT(fetch_start),
    .FETCH_ADDR_OUT(fetch_addr), .OUTPUTS_FLOATED_OUT(floated),
    .CONFIG_OUT(config_seen));
  prr_sys_end #(.RESTART_CYCLES(RC)) prr_sys_end_i (
    .CORE_CLK_IN(core_clk), .RESET_IN(reset), .BUS(pins),
    .SUPPLY_STABLE_IN(supply_stable), .STRAP_CFG_IN(strap_cfg),
    .SELFTEST_ASK_IN(selftest_ask), .RESTART_ACTIVE_OUT(restart_active),
    .TXN_VALID_OUT(txn_valid), .TXN_CODE_OUT(txn_code),
    .PARITY_ERR_OUT(parity_err));
  prr_chk #(.RESTART_CYCLES(RC)) prr_chk_i (
    .CORE_CLK_IN(core_clk), .RESET_IN(reset),
    .supply_ok(pins.supply_ok), .restart_n(pins.restart_n),
    .legacy_second_restart_n(pins.legacy_second_restart_n),
    .cpu_ads_oe(pins.cpu_ads_oe), .cpu_req_oe(pins.cpu_req_oe),
    .cpu_par_oe(pins.cpu_par_oe), .sys_req_oe(pins.sys_req_oe),
    .address_strobe_n(pins.address_strobe_n), .req_n(pins.req_n),
    .command_parity_n(pins.command_parity_n));

  // ----------
  // Shared tasks
  // ----------
  task automatic check(input logic [ADDR_W-1:0] seen,
                       input logic [ADDR_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  // Waits on fetch (0), ready (1) or self-test (2), bounded
  task automatic await(input int sel, input int lim);
    int n;
    n = 0;
    while (n < lim && !(sel == 0 ? fetch_start === 1'b1 :
           sel == 1 ? ready === 1'b1 : st_busy === 1'b1)) begin
      tick(1);
      n++;
    end
    check(n < lim, 1'b1);
  endtask

  function automatic logic exp_par(input logic [5:0] lines);
    int lows;
    lows = 0;
    for (int i = 0; i < 6; i++) begin
      if (lines[i] == 1'b0) begin
        lows++;
      end
    end
    return lows % 2 == 0;
  endfunction

  task automatic power_up(input logic [CFG_W-1:0] cfg, input logic ask);
    logic [CFG_W-1:0] lines;
    lines = ~cfg;
    @(posedge core_clk);
    strap_cfg <= cfg;
    selftest_ask <= ask;
    supply_stable <= 1'b1;
    tick(6);
    check(pins.supply_ok, 1'b1);
    check(pins.restart_n, 1'b0);
    check(cache_inv, 1'b1);
    check(pins.cpu_req_oe, 1'b0);
    check(pins.req_n, lines);
    check(pins.warm_init_n, !ask);
  endtask

  task automatic drop_supply();
    @(posedge core_clk);
    supply_stable <= 1'b0;
    req_valid <= 1'b0;
    tick(5);
    check({pins.cpu_ads_oe, pins.cpu_req_oe, pins.cpu_par_oe}, 3'h0);
    check(cache_inv, 1'b1);
    check(restart_active, 1'b1);
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic boot_plain();
    power_up(5'h0a, 1'b0);
    await(0, 60);
    check(fetch_addr, RESET_VECTOR);
    check(st_busy, 1'b0);
    check(cache_inv, 1'b0);
    check(pins.legacy_second_restart_n, 1'b1);
    await(1, 5);
    check(config_seen, 5'h0a);
  endtask

  task automatic send(input logic [CODE_W-1:0] code);
    logic [REQ_W-1:0] lo;
    logic [REQ_W-1:0] hi;
    lo = ~code[REQ_W-1:0];
    hi = ~code[CODE_W-1:REQ_W];
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_code <= code;
    #1;
    await(1, 20);
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
    check(pins.address_strobe_n, 1'b0);
    check(pins.req_n, lo);
    check(pins.command_parity_n, exp_par({1'b0, lo}));
    tick(1);
    check(pins.address_strobe_n, 1'b1);
    check(pins.req_n, hi);
    check(pins.command_parity_n, exp_par({1'b1, hi}));
    tick(1);
    check(txn_valid, 1'b1);
    check(txn_code, code);
    check(parity_err, 1'b0);
  endtask

  // Supply lost just as a request is taken, then self-test boot
  task automatic restart_selftest();
    int n;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_code <= 10'h1c7;
    #1;
    await(1, 20);
    drop_supply();
    power_up(5'h1e, 1'b1);
    await(2, 60);
    // Self-test must last exactly its configured length
    n = 0;
    while (n < 20 && fetch_start !== 1'b1) begin
      tick(1);
      n++;
    end
    check(n, ST);
    check(fetch_addr, RESET_VECTOR);
    await(1, 5);
    check(config_seen, 5'h1e);
    check(floated, 1'b0);
  endtask

  task automatic float_config();
    int bad;
    bad = 0;
    drop_supply();
    power_up(5'h01, 1'b0);
    @(posedge core_clk);
    req_valid <= 1'b1;
    repeat (60) begin
      tick(1);
      if (fetch_start === 1'b1 || pins.address_strobe_n !== 1'b1 ||
          pins.supply_ok !== 1'b1) begin
        bad++;
      end
    end
    check(bad, 0);
    check(floated, 1'b1);
    check(ready, 1'b0);
    check({pins.cpu_ads_oe, pins.cpu_req_oe, pins.cpu_par_oe}, 3'h0);
    check(config_seen, 5'h01);
  endtask

  // ----------
  // Sequence and verdict
  // ----------
  task automatic close_out();
    $display("Comparisons %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    boot_plain();
    for (int i = 0; i < 4; i++) begin
      send(CODES[i]);
    end
    restart_selftest();
    float_config();
    close_out();
  end

  // Whole run is under two hundred clocks; this is far beyond it
  initial begin
    #20000;
    errors++;
    close_out();
  end
endmodule
